// [scpip_pkg.sv]
// shared constants and types for the command parser
package scpip_pkg;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_NL = 8'h0a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_DQUOTE = 8'h22;
  localparam logic [7:0] CH_SQUOTE = 8'h27;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_LC_A = 8'h61;
  localparam logic [7:0] CH_LC_Z = 8'h7a;
  localparam logic [7:0] CASE_BIT = 8'h20;
  localparam int HDR_MAX = 12;
  localparam int COMMON_LEN = 4;
  localparam int FIFO_DEPTH = 32;
  localparam int DATA_W = 8;
  localparam int LEVEL_W = 4;
  localparam logic [15:0] ERR_TOO_LONG = 16'hff90;
  localparam logic [15:0] ERR_UNDEF_HDR = 16'hff8f;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  // token kinds handed to the command decoder
  typedef enum logic [2:0] {
    SCPIP_TK_KEYWORD, SCPIP_TK_COMMON, SCPIP_TK_NUMERIC, SCPIP_TK_DISCRETE,
    SCPIP_TK_BOOL, SCPIP_TK_STRING, SCPIP_TK_DEFAULT
  } scpip_tok_t;
endpackage

// [scpip_fifo.sv]
// input character fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module scpip_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // full and empty straight from the occupancy count
  always_comb begin
    // count is one bit wider than the pointers so a full buffer is distinct
    in_ready = (cnt_q != (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    out_data = mem_q[rd_q];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end
  end

  // pointers and storage; flush drops everything buffered
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push && !flush) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule // scpip_fifo
`default_nettype wire

// [scpip_parser.sv]
// command string tokenizer: keywords, separators, parameters, device clear
`timescale 1ns/1ps
`default_nettype none
module scpip_parser
  import scpip_pkg::*;
#(
  parameter int DEPTH = scpip_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [scpip_pkg::DATA_W-1:0] rx_data,
  input wire logic rx_eoi,
  input wire logic dev_clear_pin,
  input wire logic serial_break_pin,
  input wire logic kw_match,
  input wire logic kw_short,
  input wire logic kw_long,
  output logic tok_valid,
  output logic [2:0] tok_kind,
  output logic [scpip_pkg::DATA_W-1:0] tok_char,
  output logic tok_start,
  output logic tok_end,
  output logic [scpip_pkg::LEVEL_W-1:0] tok_level,
  output logic tok_query,
  output logic [3:0] tok_param_idx,
  output logic tok_param_empty,
  output logic msg_end,
  output logic err_valid,
  output logic [15:0] err_code,
  output logic abort_ops
);
  import scpip_pkg::*;

  typedef enum logic [2:0] {
    SCPIP_S_HDR, SCPIP_S_PARAM, SCPIP_S_STR, SCPIP_S_STRQ, SCPIP_S_CR, SCPIP_S_SKIP
  } scpip_state_t;

  // fold lower case to upper so matching ignores case
  function automatic logic [7:0] upcase(input logic [7:0] c);
    return (c >= CH_LC_A && c <= CH_LC_Z) ? (c & ~CASE_BIT) : c;
  endfunction

  logic [1:0] clr_sync_q, brk_sync_q;
  logic [1:0] clr_sync_d, brk_sync_d;
  logic dev_clear;
  logic f_valid, f_ready;
  logic [7:0] f_data;
  logic f_eoi;

  // pin synchronisers; only the second stage is read
  always_comb begin
    clr_sync_d = {clr_sync_q[0], dev_clear_pin};
    brk_sync_d = {brk_sync_q[0], serial_break_pin};
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clr_sync_q <= '0;
      brk_sync_q <= '0;
    end else begin
      clr_sync_q <= clr_sync_d;
      brk_sync_q <= brk_sync_d;
    end
  end
  assign dev_clear = clr_sync_q[1] || brk_sync_q[1];

  // buffered input with back-pressure; eoi travels as bit 8
  scpip_fifo #(.WIDTH(DATA_W + 1), .DEPTH(DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .flush(dev_clear),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data({rx_eoi, rx_data}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data({f_eoi, f_data})
  );
  assign f_ready = 1'b1;

  scpip_state_t st_q, st_d;
  logic [LEVEL_W-1:0] lvl_q, lvl_d, base_q, base_d;
  logic [3:0] hlen_q, hlen_d, pidx_q, pidx_d;
  logic first_q, first_d, semi_q, semi_d, common_q, common_d;
  logic [7:0] quote_q, quote_d;
  logic tv_d, ts_d, te_d, tq_d, tpe_d, me_d, ev_d, ab_d;
  logic [2:0] tk_d;
  logic [7:0] tc_d;
  logic [15:0] ec_d;
  logic [7:0] c;
  logic term;

  // tokenizer next state
  always_comb begin
    c = upcase(f_data);
    term = f_eoi || (f_data == CH_NL);
    st_d = st_q;
    lvl_d = lvl_q;
    base_d = base_q;
    hlen_d = hlen_q;
    pidx_d = pidx_q;
    first_d = first_q;
    semi_d = semi_q;
    common_d = common_q;
    quote_d = quote_q;
    tv_d = 1'b0;
    ts_d = 1'b0;
    te_d = 1'b0;
    tq_d = 1'b0;
    tpe_d = 1'b0;
    me_d = 1'b0;
    ev_d = 1'b0;
    ab_d = 1'b0;
    tk_d = 3'(SCPIP_TK_KEYWORD);
    tc_d = c;
    ec_d = ERR_NONE;
    if (dev_clear) begin
      // restart parse only; settings live elsewhere
      ab_d = 1'b1;
      st_d = SCPIP_S_HDR;
      lvl_d = '0;
      base_d = '0;
      hlen_d = '0;
      first_d = 1'b1;
      semi_d = 1'b0;
    end else if (f_valid) begin
      if (term && st_q != SCPIP_S_STR) begin
        me_d = 1'b1;
        te_d = 1'b1;
        tpe_d = (st_q == SCPIP_S_HDR);
        // keyword ended by the terminator still gets its verdict
        if ((st_q == SCPIP_S_HDR || st_q == SCPIP_S_CR) && !common_q && hlen_q != '0
            && (!kw_match || !(kw_short || kw_long))) begin
          ev_d = 1'b1;
          ec_d = ERR_UNDEF_HDR;
        end
        st_d = SCPIP_S_HDR;
        lvl_d = '0;
        base_d = '0;
        hlen_d = '0;
        pidx_d = '0;
        first_d = 1'b1;
        semi_d = 1'b0;
        common_d = 1'b0;
      end else if (f_data == CH_CR && st_q != SCPIP_S_STR) begin
        st_d = SCPIP_S_CR;
      end else begin
        unique case (st_q)
          SCPIP_S_HDR, SCPIP_S_CR: begin
            if (f_data == CH_COLON) begin
              // leading colon after semicolon restarts at root
              if (first_q) begin
                lvl_d = '0;
              end else begin
                lvl_d = lvl_q + 1'b1;
                te_d = 1'b1;
              end
              first_d = 1'b0;
              hlen_d = '0;
            end else if (f_data == CH_SPACE) begin
              if (!first_q) begin
                st_d = SCPIP_S_PARAM;
                te_d = 1'b1;
              end
            end else if (f_data == CH_SEMI) begin
              te_d = 1'b1;
              tpe_d = 1'b1;
              lvl_d = base_q;
              first_d = 1'b1;
              semi_d = 1'b1;
              hlen_d = '0;
            end else begin
              // path of the keyword in progress; a semicolon returns here
              base_d = lvl_q;
              first_d = 1'b0;
              ts_d = (hlen_q == '0);
              common_d = (hlen_q == '0) ? (f_data == CH_STAR) : common_q;
              tq_d = (f_data == CH_QUERY);
              tv_d = 1'b1;
              tk_d = ((hlen_q == '0) ? (f_data == CH_STAR) : common_q)
                ? 3'(SCPIP_TK_COMMON) : 3'(SCPIP_TK_KEYWORD);
              hlen_d = (hlen_q == 4'(HDR_MAX)) ? hlen_q : hlen_q + 1'b1;
              if (hlen_q == 4'(HDR_MAX)) begin
                ev_d = 1'b1;
                ec_d = ERR_TOO_LONG;
                st_d = SCPIP_S_SKIP;
              end else if (common_q && hlen_q >= 4'(COMMON_LEN)
                           && f_data != CH_QUERY) begin
                // common token longer than three letters
                ev_d = 1'b1;
                ec_d = ERR_UNDEF_HDR;
                st_d = SCPIP_S_SKIP;
              end
            end
            if (te_d && !common_q && hlen_q != '0) begin
              // decoder match verdict at keyword end
              if (!kw_match || !(kw_short || kw_long)) begin
                ev_d = 1'b1;
                ec_d = ERR_UNDEF_HDR;
                st_d = SCPIP_S_SKIP;
              end
            end
          end
          SCPIP_S_PARAM: begin
            tv_d = 1'b1;
            tc_d = c;
            if ((f_data >= CH_ZERO && f_data <= 8'h39) || f_data == CH_PLUS
                || f_data == CH_MINUS || f_data == CH_DOT) begin
              // bare 0 or 1 also serves as boolean
              tk_d = 3'(SCPIP_TK_NUMERIC);
            end else begin
              // words such as MIN, MAX, ON, OFF
              tk_d = 3'(SCPIP_TK_DISCRETE);
            end
            if (f_data == CH_COMMA) begin
              tv_d = 1'b0;
              te_d = 1'b1;
              pidx_d = pidx_q + 1'b1;
            end else if (f_data == CH_SEMI) begin
              tv_d = 1'b0;
              te_d = 1'b1;
              st_d = SCPIP_S_HDR;
              lvl_d = base_q;
              first_d = 1'b1;
              semi_d = 1'b1;
              hlen_d = '0;
              pidx_d = '0;
            end else if (f_data == CH_DQUOTE || f_data == CH_SQUOTE) begin
              tv_d = 1'b0;
              quote_d = f_data;
              st_d = SCPIP_S_STR;
            end else if (f_data == CH_SPACE) begin
              tv_d = 1'b0;
            end
          end
          SCPIP_S_STR: begin
            tk_d = 3'(SCPIP_TK_STRING);
            tc_d = f_data;
            if (f_data == quote_q) begin
              st_d = SCPIP_S_STRQ;
            end else begin
              tv_d = 1'b1;
            end
          end
          SCPIP_S_STRQ: begin
            if (f_data == quote_q) begin
              tv_d = 1'b1;
              tk_d = 3'(SCPIP_TK_STRING);
              tc_d = f_data;
              st_d = SCPIP_S_STR;
            end else begin
              st_d = SCPIP_S_PARAM;
              te_d = (f_data == CH_COMMA);
              pidx_d = (f_data == CH_COMMA) ? pidx_q + 1'b1 : pidx_q;
            end
          end
          SCPIP_S_SKIP: begin
            // discard until terminator or carriage return; chars in between yield no tokens
          end
        endcase
      end
    end
  end

  // register tokenizer state and outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= SCPIP_S_HDR;
      lvl_q <= '0;
      base_q <= '0;
      hlen_q <= '0;
      pidx_q <= '0;
      first_q <= 1'b1;
      semi_q <= 1'b0;
      common_q <= 1'b0;
      quote_q <= '0;
      tok_valid <= 1'b0;
      tok_kind <= '0;
      tok_char <= '0;
      tok_start <= 1'b0;
      tok_end <= 1'b0;
      tok_level <= '0;
      tok_query <= 1'b0;
      tok_param_idx <= '0;
      tok_param_empty <= 1'b0;
      msg_end <= 1'b0;
      err_valid <= 1'b0;
      err_code <= ERR_NONE;
      abort_ops <= 1'b0;
    end else begin
      st_q <= st_d;
      lvl_q <= lvl_d;
      base_q <= base_d;
      hlen_q <= hlen_d;
      pidx_q <= pidx_d;
      first_q <= first_d;
      semi_q <= semi_d;
      common_q <= common_d;
      quote_q <= quote_d;
      tok_valid <= tv_d;
      tok_kind <= tk_d;
      tok_char <= tc_d;
      tok_start <= ts_d;
      tok_end <= te_d;
      tok_level <= lvl_q;
      tok_query <= tq_d;
      tok_param_idx <= pidx_q;
      tok_param_empty <= tpe_d;
      msg_end <= me_d;
      err_valid <= ev_d;
      err_code <= ec_d;
      abort_ops <= ab_d;
    end
  end

  // clear pulse follows the synchronised request
  // abort on clear
  clear_abort_a: assert property (@(posedge core_clk) disable iff (rst)
    dev_clear |=> abort_ops) else $error("abort missing after clear");
  // terminator resets path
  path_root_a: assert property (@(posedge core_clk) disable iff (rst)
    msg_end |-> lvl_q == '0) else $error("path not at root");
  // header length error
  hdr_long_a: assert property (@(posedge core_clk) disable iff (rst)
    err_valid && err_code == ERR_TOO_LONG |-> st_q == SCPIP_S_SKIP)
    else $error("long header not skipped");
  // buffer backpressure
  fifo_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    !rx_ready |=> u_fifo.cnt_q <= $past(u_fifo.cnt_q))
    else $error("fifo grew while full");
  // semicolon then colon lands at root
  semi_root_a: assert property (@(posedge core_clk) disable iff (rst)
    f_valid && semi_q && first_q && f_data == CH_COLON && !f_eoi && !dev_clear
    && st_q != SCPIP_S_SKIP |=> lvl_q == '0) else $error("no root after semicolon");
  // break acts as clear
  break_clr_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(brk_sync_q[1]) |=> abort_ops) else $error("break ignored");
endmodule // scpip_parser
`default_nettype wire

// [scpip_host.sv]
// host-side model that sends command strings over the character stream
`timescale 1ns/1ps
`default_nettype none
module scpip_host (
  input wire logic core_clk,
  output var logic rx_valid,
  input wire logic rx_ready,
  output var logic [7:0] rx_data,
  output var logic rx_eoi
);
  // idle line at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_eoi = 1'b0;
  end

  // one char per handshake, random stalls between chars
  task automatic send(input string s, input bit eoi_last);
    int gap;
    @(posedge core_clk);
    for (int i = 0; i < s.len(); i++) begin
      rx_valid <= 1'b1;
      rx_data <= s[i];
      rx_eoi <= eoi_last && (i == s.len() - 1);
      do @(posedge core_clk); while (!rx_ready);
      gap = $urandom_range(2);
      if (gap != 0 || i == s.len() - 1) begin
        rx_valid <= 1'b0;
        rx_eoi <= 1'b0;
        // released data inverted so a stale char can never look valid
        rx_data <= ~s[i];
        repeat (gap) @(posedge core_clk);
      end
    end
  endtask
endmodule // scpip_host
`default_nettype wire

// [scpip_tb.sv]
// self-checking bench for the command parser
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin mismatches++; $display("ERROR %0t: %s", $time, m); end end
module tb;
  import scpip_pkg::*;
  typedef struct {logic [7:0] ch; logic [3:0] lvl; bit kw;} scpip_exp_t;
  logic core_clk, rst, rx_valid, rx_ready, rx_eoi, dev_clear_pin, serial_break_pin;
  logic kw_match, kw_short, kw_long, tok_valid, tok_start, tok_end, tok_query;
  logic tok_param_empty, msg_end, err_valid, abort_ops;
  logic [7:0] rx_data, tok_char;
  logic [2:0] tok_kind;
  logic [3:0] tok_level, tok_param_idx;
  logic [15:0] err_code;
  int mismatches, n_tests, msgs_exp, msgs_got, aborts, cyc;
  bit ign;
  scpip_exp_t tq[$];
  logic [15:0] eq[$];

  scpip_host host (.core_clk(core_clk), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_eoi(rx_eoi));
  scpip_parser DUT (.core_clk(core_clk), .rst(rst), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_eoi(rx_eoi), .dev_clear_pin(dev_clear_pin),
    .serial_break_pin(serial_break_pin), .kw_match(kw_match), .kw_short(kw_short),
    .kw_long(kw_long), .tok_valid(tok_valid), .tok_kind(tok_kind), .tok_char(tok_char),
    .tok_start(tok_start), .tok_end(tok_end), .tok_level(tok_level), .tok_query(tok_query),
    .tok_param_idx(tok_param_idx), .tok_param_empty(tok_param_empty), .msg_end(msg_end),
    .err_valid(err_valid), .err_code(err_code), .abort_ops(abort_ops));

  // 10 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // expected tokens of one message: path level tracked per char
  function automatic void expect_msg(string s);
    int lvl;
    bit hdr, par, semi, str;
    byte q;
    lvl = 0;
    hdr = 0;
    par = 0;
    semi = 0;
    str = 0;
    q = 0;
    for (int i = 0; i < s.len(); i++) begin
      byte c;
      c = s[i];
      if (str) begin
        if (c == q && i + 1 < s.len() && s[i+1] == q) begin
          tq.push_back('{c, 4'h0, 1'b0});
          i++;
        end else if (c == q) str = 0;
        else tq.push_back('{c, 4'h0, 1'b0});
      end else if (c == CH_COLON) begin
        lvl = semi ? 0 : lvl + 1;
        semi = 0;
      end else if (c == CH_SEMI) begin
        semi = 1;
        hdr = 0;
        par = 0;
      end else if (c == CH_SPACE) begin
        if (hdr) par = 1;
      end else if (c == CH_SQUOTE || c == CH_DQUOTE) begin
        str = 1;
        q = c;
      end else if (c != CH_CR && c != CH_NL && c != CH_COMMA) begin
        semi = 0;
        hdr = 1;
        tq.push_back('{(c >= CH_LC_A && c <= CH_LC_Z) ? c ^ CASE_BIT : c, 4'(lvl), !par});
      end
    end
  endfunction

  // random case flips on letters; expectations stay upper case
  function automatic string mix(string s);
    for (int i = 0; i < s.len(); i++) begin
      if ((s[i] | 8'h20) >= CH_LC_A && (s[i] | 8'h20) <= CH_LC_Z && $urandom_range(1) == 1)
        s[i] = s[i] ^ CASE_BIT;
    end
    return s;
  endfunction

  // wait, bounded, until every noted result has shown up
  task automatic drain;
    for (int k = 0; k < 60 && (tq.size() != 0 || eq.size() != 0); k++) @(posedge core_clk);
    repeat (6) @(posedge core_clk);
  endtask

  // one whole message; erroneous ones are judged by their error code only
  task automatic run(string s, bit eoi, logic [15:0] err);
    msgs_exp++;
    if (err !== ERR_NONE) begin
      eq.push_back(err);
      ign = 1;
    end else expect_msg(s);
    host.send(s, eoi);
    drain;
    ign = 0;
  endtask

  // hold a clear source for n cycles and count the abort pulses
  task automatic clear_pulse(bit brk, int n);
    int a0;
    a0 = aborts;
    if (brk) serial_break_pin <= 1'b1;
    else dev_clear_pin <= 1'b1;
    repeat (n) @(posedge core_clk);
    serial_break_pin <= 1'b0;
    dev_clear_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
    `CHK(aborts - a0, n, "abort pulse count")
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // watcher: take the oldest note whenever a result appears
  always @(posedge core_clk) begin
    scpip_exp_t e;
    if (!rst) begin
      if (tok_valid === 1'b1 && !ign) begin
        if (tq.size() == 0) `CHK(1'b1, 1'b0, "token with no expectation")
        else begin
          e = tq.pop_front();
          `CHK(tok_char, e.ch, "token char")
          if (e.kw && tok_kind === 3'(SCPIP_TK_KEYWORD)) `CHK(tok_level, e.lvl, "path level")
          if (e.kw && e.ch == CH_QUERY) `CHK(tok_query, 1'b1, "query flag")
        end
      end
      if (err_valid === 1'b1) begin
        if (eq.size() == 0) `CHK(1'b1, 1'b0, "unexpected error")
        else `CHK(err_code, eq.pop_front(), "error code")
      end
      if (msg_end === 1'b1) msgs_got++;
      if (abort_ops === 1'b1) aborts++;
    end
  end

  // hang guard, well above the several hundred cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      $display("ERROR %0t: timeout", $time);
      wrap_up;
    end
  end

  initial begin
    rst = 1'b1;
    dev_clear_pin = 1'b0;
    serial_break_pin = 1'b0;
    kw_match = 1'b1;
    kw_short = 1'b1;
    kw_long = 1'b0;
    ign = 0;
    void'($urandom(48881));
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    run(mix("SOUR:FREQ:STAR 10;STOP 1000\n"), 0, ERR_NONE);
    run(mix("swe:stat on; :trig:sour ext\015\n"), 0, ERR_NONE);
    // several params; eoi rides on a closing blank
    run("APPL:SIN 5 KHZ, 3.0 VPP, -2.5 V ", 1, ERR_NONE);
    run(mix("*rst; *opc?\n"), 0, ERR_NONE);
    run("DISP:TEXT 'a''b'\n", 0, ERR_NONE);
    run(mix("FREQ? MIN\n"), 0, ERR_NONE);
    run("SOURCEFREQUENCYX 1\n", 0, ERR_TOO_LONG);
    kw_match <= 1'b0;
    kw_short <= 1'b0;
    run("BOGUS\n", 0, ERR_UNDEF_HDR);
    kw_match <= 1'b1;
    kw_short <= 1'b1;
    // a clear drops the unfinished path
    expect_msg("SOUR:FR");
    host.send("SOUR:FR", 0);
    drain;
    clear_pulse(0, 5);
    run(mix("freq?\n"), 0, ERR_NONE);
    expect_msg("SWE:TIME");
    host.send("SWE:TIME", 0);
    drain;
    clear_pulse(1, 3);
    run("TRIG\n", 0, ERR_NONE);
    `CHK(tq.size(), 0, "tokens missing")
    `CHK(eq.size(), 0, "errors missing")
    `CHK(msgs_got, msgs_exp, "terminator count")
    wrap_up;
  end
endmodule // tb
`default_nettype wire
